// File: design/ppc_pkg.sv
// Shared constants, pin bundles and state codes of the parallel port controller.
// Assumes a single 50 MHz system clock; every time below is turned into cycles here.
package ppc_pkg;

   // Clock and handshake timing
   localparam int CLK_NS       = 20;
   localparam int ACK_BASE_NS  = 500;
   localparam int ACK_STEP_NS  = 100;
   localparam int ACK_BASE_CYC = (ACK_BASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACK_STEP_CYC = (ACK_STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACK_CNT_W    = 12;
   localparam int HOLDOFF_CYC  = 20;
   localparam int HOLD_W       = 5;
   localparam int ALIGN_EDGES  = 2;
   localparam int BYTE_W       = 8;
   localparam int RLE_W        = 7;

   // Register map, byte addresses
   localparam int          APB_AW    = 8;
   localparam logic [7:0]  OFS_PAC   = 8'h00;
   localparam logic [7:0]  OFS_PULSE = 8'h04;
   localparam logic [7:0]  OFS_QTY   = 8'h08;
   localparam logic [7:0]  OFS_RLE   = 8'h0C;
   localparam logic [7:0]  OFS_EOS   = 8'h10;
   localparam logic [7:0]  OFS_STAT  = 8'h14;

   // Field positions
   localparam int PAC_REVERSE = 0;
   localparam int PAC_ASYNC   = 1;
   localparam int PAC_FLUSH   = 2;
   localparam int STAT_DIRCH  = 0;
   localparam int STAT_HREV   = 1;
   localparam logic [7:0] PULSE_RESET = 8'h00;

   // Host bus pins seen by the device
   typedef struct packed {
      logic              cs_n;
      logic              data_strobe_n;
      logic              rw_n;
      logic              service_ack_n;
      logic              chain_grant_in_n;
      logic              dma_acknowledge_n;
      logic [BYTE_W-1:0] data;
   } ppc_host_in_t;

   // Pins from the attached 1284 host
   typedef struct packed {
      logic              strobe_n;
      logic              dir_reverse;
      logic [BYTE_W-1:0] data;
   } ppc_link_in_t;

   localparam ppc_host_in_t HOST_IN_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h00};
   localparam ppc_link_in_t LINK_IN_IDLE = '{1'b1, 1'b0, 8'h00};

   typedef enum logic [5:0] {
      H_IDLE = 6'h01, H_C1 = 6'h02, H_C2 = 6'h04,
      H_C3   = 6'h08, H_WAIT = 6'h10, H_DONE = 6'h20
   } ppc_host_st_t;

   typedef enum logic [4:0] {
      D_IDLE = 5'h01, D_C1 = 5'h02, D_C2 = 5'h04, D_C3 = 5'h08, D_AWAIT = 5'h10
   } ppc_dma_st_t;

   typedef enum logic [3:0] {
      L_IDLE = 4'h1, L_BUSY = 4'h2, L_ACK = 4'h4, L_TAIL = 4'h8
   } ppc_link_st_t;

endpackage

// File: design/ppc_fifo.sv
// Parallel FIFO between the host bus side and the 1284 link side.
// Assumes one pusher and one popper per cycle; overflow and underflow are ignored.
`timescale 1ns/1ps
module ppc_fifo
   import ppc_pkg::*;
#(
   parameter  int WIDTH = 8,
   parameter  int DEPTH = 64,
   localparam int CW    = $clog2(DEPTH + 1),
   localparam int AW    = $clog2(DEPTH)
) (
   // Clock, reset, enable
   input  wire logic             sys_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Control
   input  wire logic             flush,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic             pop,
   // State
   output logic      [WIDTH-1:0] head,
   output logic      [CW-1:0]    count,
   output logic                  full,
   output logic                  empty
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic             do_push;
   logic             do_pop;

   // Wrap explicitly so a depth that is no power of two still works
   function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign full    = (count == CW'(DEPTH));
   assign empty   = (count == '0);
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;
   assign head    = mem[rd_ptr];

   // Pointers and fill level; flush beats any transfer in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else if (ce) begin
         if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
         end else begin
            if (do_push) wr_ptr <= next_ptr(wr_ptr);
            if (do_pop) rd_ptr <= next_ptr(rd_ptr);
            count <= count + CW'(do_push) - CW'(do_pop);
         end
      end
   end

   // Storage array, no reset needed
   always_ff @(posedge sys_clk) begin
      if (ce && do_push) begin
         mem[wr_ptr] <= wdata;
      end
   end

endmodule

// File: design/ppc_port.sv
// Parallel port controller: synchronous host bus cycles, DMA, 1284 compatible handshake.
// Assumes host and link pins are asynchronous to sys_clk; registers sit behind APB.
//
// Function
// - Transfer acknowledge goes low from the edge starting the third cycle.
// - Data bus is released once chip select and strobe end the access.
// - Access after service-ack or end-of-service write waits 20 clocks for acknowledge.
// - Each synchronous DMA transfer lasts three clocks; transfers may follow back to back.
// - Compatible mode acknowledge pulse is 500 ns by default.
// - Pulse-width register lengthens acknowledge and slows the other direction too.
// - Busy is extended together with acknowledge, keeping acknowledge inside busy.
// - Only the ack-in-busy ordering exists, never ack-while-busy.
// - Reverse-to-forward switch with data still queued raises direction-change flag.
// - FIFO quantity register reads the bytes held in the FIFO.
// - Software can flush the FIFO and set its direction to forward.
// - Run-length count register reads the current repeat count.
// - Asynchronous DMA handshake only with the async select bit set.
// - Cycle numbering starts two rising edges after reset release.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module ppc_port
   import ppc_pkg::*;
#(
   parameter  int FIFO_DEPTH = 64,
   localparam int QW         = $clog2(FIFO_DEPTH + 1)
) (
   // Clock, reset, enable
   input  wire logic               sys_clk,
   input  wire logic               rst_n,
   input  wire logic               ce,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [APB_AW-1:0]  paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Host bus pins
   input  wire ppc_host_in_t       host_in,
   output logic      [BYTE_W-1:0]  host_data_out,
   output logic                    host_data_oe,
   output logic                    transfer_ack_n,
   output logic                    transfer_ack_oe,
   output logic                    chain_grant_out_n,
   output logic                    dma_request_n,
   // 1284 link pins
   input  wire ppc_link_in_t       link_in,
   output logic      [BYTE_W-1:0]  periph_data,
   output logic                    periph_data_oe,
   output logic                    periph_ack_n,
   output logic                    periph_busy,
   // Status level
   output logic                    dir_change_flag
);

   ppc_host_in_t           host_meta;
   ppc_host_in_t           host_s;
   ppc_link_in_t           link_meta;
   ppc_link_in_t           link_s;
   logic                   strobe_d;
   logic                   rev_d;
   logic [1:0]             align_cnt;
   logic                   align_done;
   logic                   rev_mode;
   logic                   async_dma;
   logic [7:0]             pulse_width;
   logic [RLE_W-1:0]       rle_count;
   logic [BYTE_W-1:0]      last_byte;
   logic [HOLD_W-1:0]      hold_cnt;
   logic [ACK_CNT_W-1:0]   ack_cnt;
   logic [ACK_CNT_W-1:0]   pulse_len;
   ppc_host_st_t           h_st;
   ppc_host_st_t           next_h_st;
   ppc_dma_st_t            d_st;
   ppc_dma_st_t            next_d_st;
   ppc_link_st_t           l_st;
   ppc_link_st_t           next_l_st;
   logic                   h_rd;
   logic                   h_svc;
   logic                   l_rev;
   logic                   ack_pullup;
   logic [31:0]            rd_mux;
   logic [BYTE_W-1:0]      fifo_head;
   logic [QW-1:0]          fifo_count;
   logic                   fifo_full;
   logic                   fifo_empty;

   // Two-flop synchronisers; only the second stage feeds any logic
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         host_meta <= HOST_IN_IDLE;
         host_s    <= HOST_IN_IDLE;
         link_meta <= LINK_IN_IDLE;
         link_s    <= LINK_IN_IDLE;
         strobe_d  <= 1'b1;
         rev_d     <= 1'b0;
      end else if (ce) begin
         host_meta <= host_in;
         host_s    <= host_meta;
         link_meta <= link_in;
         link_s    <= link_meta;
         strobe_d  <= link_s.strobe_n;
         rev_d     <= link_s.dir_reverse;
      end
   end

   // Cycle alignment after reset release
   assign align_done = (align_cnt == 2'(ALIGN_EDGES));
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         align_cnt <= '0;
      end else if (ce && !align_done) begin
         align_cnt <= align_cnt + 1'b1;
      end
   end

   // APB decode; zero wait states, read data is latched in the setup cycle
   wire apb_wr   = psel & penable & pwrite;
   wire hit_pac  = (paddr == OFS_PAC);
   wire hit_pw   = (paddr == OFS_PULSE);
   wire hit_qty  = (paddr == OFS_QTY);
   wire hit_rle  = (paddr == OFS_RLE);
   wire hit_eos  = (paddr == OFS_EOS);
   wire hit_stat = (paddr == OFS_STAT);
   wire mapped   = hit_pac | hit_pw | hit_qty | hit_rle | hit_eos | hit_stat;
   wire flush    = apb_wr & hit_pac & pwdata[PAC_FLUSH];
   wire eos_wr   = apb_wr & hit_eos;
   wire dirch_clr = apb_wr & hit_stat & pwdata[STAT_DIRCH];
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Read word selection; unused bits read as zero
   always_comb begin
      rd_mux = '0;
      if (hit_pac) begin
         rd_mux[PAC_REVERSE] = rev_mode;
         rd_mux[PAC_ASYNC]   = async_dma;
      end
      if (hit_pw) rd_mux[7:0] = pulse_width;
      if (hit_qty) rd_mux[QW-1:0] = fifo_count;
      if (hit_rle) rd_mux[RLE_W-1:0] = rle_count;
      if (hit_stat) begin
         rd_mux[STAT_DIRCH] = dir_change_flag;
         rd_mux[STAT_HREV]  = link_s.dir_reverse;
      end
   end

   // Software registers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rev_mode    <= 1'b0;
         async_dma   <= 1'b0;
         pulse_width <= PULSE_RESET;
         prdata      <= '0;
      end else if (ce) begin
         if (psel && !penable) prdata <= rd_mux;
         if (apb_wr && hit_pac) begin
            rev_mode  <= pwdata[PAC_REVERSE];
            async_dma <= pwdata[PAC_ASYNC];
         end
         if (apb_wr && hit_pw) pulse_width <= pwdata[7:0];
      end
   end

   // Requests seen on the host bus
   wire host_req = ~host_s.cs_n & ~host_s.data_strobe_n;
   wire svc_req  = ~host_s.service_ack_n & ~host_s.chain_grant_in_n & ~host_s.data_strobe_n;
   wire host_end = host_s.data_strobe_n & host_s.cs_n & host_s.chain_grant_in_n;
   wire hold_zero = (hold_cnt == '0);
   wire ack_fire = ((h_st == H_C2) || (h_st == H_WAIT)) && hold_zero;
   wire host_pop = ack_fire & h_rd & ~h_svc & ~rev_mode;
   wire host_push = ack_fire & ~h_rd & ~h_svc & rev_mode;

   // Pass the daisy-chain grant on unless this device claims the service cycle
   assign chain_grant_out_n = host_s.chain_grant_in_n | host_s.data_strobe_n | ~host_s.service_ack_n;

   // Host cycle sequencer
   always_comb begin
      next_h_st = h_st;
      unique case (h_st)
         H_IDLE: if (align_done && d_st == D_IDLE && (host_req || svc_req)) next_h_st = H_C1;
         H_C1:   next_h_st = H_C2;
         H_C2:   next_h_st = hold_zero ? H_C3 : H_WAIT;
         H_C3:   next_h_st = H_DONE;
         H_WAIT: if (hold_zero) next_h_st = H_C3;
         H_DONE: if (host_end) next_h_st = H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         h_st  <= H_IDLE;
         h_rd  <= 1'b1;
         h_svc <= 1'b0;
      end else if (ce) begin
         h_st <= next_h_st;
         if (h_st == H_IDLE) begin
            h_rd  <= host_s.rw_n;
            h_svc <= svc_req & ~host_req;
         end
      end
   end

   // Hold-off after a service cycle or an end-of-service write; a host that
   // does not watch the acknowledge must not access during this time
   wire svc_done = (h_st == H_DONE) & host_end & h_svc;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hold_cnt <= '0;
      end else if (ce) begin
         if (svc_done || eos_wr) hold_cnt <= HOLD_W'(HOLDOFF_CYC);
         else if (!hold_zero) hold_cnt <= hold_cnt - 1'b1;
      end
   end

   // Acknowledge drive: low until the host ends, then one cycle of active pull-up
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         transfer_ack_n  <= 1'b1;
         transfer_ack_oe <= 1'b0;
         ack_pullup      <= 1'b0;
      end else if (ce) begin
         if (ack_fire) transfer_ack_n <= 1'b0;
         else if (h_st == H_DONE && host_end) transfer_ack_n <= 1'b1;
         ack_pullup      <= ~transfer_ack_n & (h_st == H_DONE) & host_end;
         transfer_ack_oe <= ack_fire | (~transfer_ack_n & ~(h_st == H_DONE && host_end)) |
                            (~transfer_ack_n & (h_st == H_DONE) & host_end);
         if (ack_pullup) transfer_ack_oe <= 1'b0;
      end
   end

   // DMA sequencer: three cycles per transfer, async variant waits for release
   wire dma_ready = rev_mode ? ~fifo_full : ~fifo_empty;
   wire dma_ack   = ~host_s.dma_acknowledge_n;
   wire dma_go    = align_done & dma_ack & dma_ready;
   // Back to back only if a byte or a slot is left once this transfer is done
   wire dma_more  = dma_ack & (rev_mode ? (fifo_count < QW'(FIFO_DEPTH - 1)) : (fifo_count > QW'(1)));
   wire dma_xfer  = (d_st == D_C3);
   wire dma_pop   = dma_xfer & ~rev_mode;
   wire dma_push  = dma_xfer & rev_mode;
   assign dma_request_n = ~(align_done & dma_ready & (h_st == H_IDLE));

   always_comb begin
      next_d_st = d_st;
      unique case (d_st)
         D_IDLE:  if (dma_go && h_st == H_IDLE) next_d_st = D_C1;
         D_C1:    next_d_st = D_C2;
         D_C2:    next_d_st = D_C3;
         D_C3:    if (async_dma) next_d_st = D_AWAIT;
                  else if (dma_more) next_d_st = D_C1;
                  else next_d_st = D_IDLE;
         D_AWAIT: if (!dma_ack) next_d_st = D_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         d_st <= D_IDLE;
      end else if (ce) begin
         d_st <= next_d_st;
      end
   end

   // Shared data bus; head is sampled after any pop has settled
   wire host_drive = h_rd & ~h_svc & ~rev_mode & (next_h_st != H_IDLE) & (next_h_st != H_C1);
   wire dma_drive  = ~rev_mode & (next_d_st != D_IDLE);
   wire data_load  = (h_st == H_C1) | (h_st == H_WAIT) | (d_st == D_C1);
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         host_data_out <= '0;
         host_data_oe  <= 1'b0;
      end else if (ce) begin
         host_data_oe <= host_drive | dma_drive;
         if (data_load) host_data_out <= fifo_head;
      end
   end

   // Link side: compatible handshake with ack-in-busy ordering
   wire strobe_fall = strobe_d & ~link_s.strobe_n;
   wire link_push = (l_st == L_IDLE) & align_done & ~rev_mode & ~link_s.dir_reverse & strobe_fall & ~fifo_full;
   wire link_pop  = (l_st == L_IDLE) & align_done & rev_mode & link_s.dir_reverse & ~fifo_empty & ~link_push;
   wire ack_zero  = (ack_cnt == '0);
   assign pulse_len = ACK_CNT_W'(ACK_BASE_CYC) + ACK_CNT_W'(pulse_width) * ACK_CNT_W'(ACK_STEP_CYC);

   always_comb begin
      next_l_st = l_st;
      unique case (l_st)
         L_IDLE: if (link_push || link_pop) next_l_st = L_BUSY;
         L_BUSY: if (l_rev || link_s.strobe_n) next_l_st = L_ACK;
         L_ACK:  if (ack_zero) next_l_st = L_TAIL;
         L_TAIL: next_l_st = L_IDLE;
      endcase
   end

   // Pulse timer also paces reverse bytes, so a longer pulse slows both directions
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         l_st    <= L_IDLE;
         l_rev   <= 1'b0;
         ack_cnt <= '0;
      end else if (ce) begin
         l_st <= next_l_st;
         if (l_st == L_IDLE) l_rev <= link_pop;
         if (l_st == L_BUSY) ack_cnt <= pulse_len - 1'b1;
         else if (l_st == L_ACK && !ack_zero) ack_cnt <= ack_cnt - 1'b1;
      end
   end

   // Link outputs: busy brackets the whole acknowledge pulse
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         periph_ack_n   <= 1'b1;
         periph_busy    <= 1'b0;
         periph_data    <= '0;
         periph_data_oe <= 1'b0;
      end else if (ce) begin
         periph_ack_n   <= ~(next_l_st == L_ACK);
         periph_busy    <= (next_l_st != L_IDLE) | (~rev_mode & fifo_full);
         periph_data_oe <= rev_mode & link_s.dir_reverse;
         if (link_pop) periph_data <= fifo_head;
      end
   end

   // Direction change flag; a new event wins over a clear in the same cycle
   wire dirch_set = rev_d & ~link_s.dir_reverse & rev_mode & ~fifo_empty;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dir_change_flag <= 1'b0;
      end else if (ce) begin
         dir_change_flag <= dirch_set | (dir_change_flag & ~dirch_clr);
      end
   end

   // Run-length counter over repeated forward bytes, saturating
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rle_count <= '0;
         last_byte <= '0;
      end else if (ce) begin
         if (flush) begin
            rle_count <= '0;
         end else if (link_push) begin
            last_byte <= link_s.data;
            if (link_s.data != last_byte) rle_count <= '0;
            else if (rle_count != '1) rle_count <= rle_count + 1'b1;
         end
      end
   end

   // FIFO; direction decides which side fills and which drains
   ppc_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .flush   (flush),
      .push    (link_push | host_push | dma_push),
      .wdata   (rev_mode ? host_s.data : link_s.data),
      .pop     (link_pop | host_pop | dma_pop),
      .head    (fifo_head),
      .count   (fifo_count),
      .full    (fifo_full),
      .empty   (fifo_empty)
   );

endmodule

// File: dv/ppc_port_assertions.sv
// Concurrent checks on the ports of ppc_port.
// Assumes ce stays high and no service cycles; bound below.
`timescale 1ns/1ps
module ppc_port_assertions
   import ppc_pkg::*;
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              rst_n,
   // APB
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic              pready,
   input wire logic              pslverr,
   // Host and link pins
   input wire ppc_host_in_t      host_in,
   input wire logic              host_data_oe,
   input wire logic              transfer_ack_n,
   input wire logic              transfer_ack_oe,
   input wire logic              periph_ack_n,
   input wire logic              periph_busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic [ACK_CNT_W-1:0] ack_len;
   logic [HOLD_W-1:0]    hold;
   logic                 eos_wr;
   assign eos_wr = psel && penable && pwrite && (paddr == OFS_EOS);
   // Link acknowledge low time; read at the rising edge of the pulse
   always_ff @(posedge sys_clk) begin
      if (!rst_n || periph_ack_n) ack_len <= '0;
      else ack_len <= ack_len + 1'b1;
   end
   // Hold-off shadow, three cycles short to allow for pin synchronisers
   always_ff @(posedge sys_clk) begin
      if (!rst_n) hold <= '0;
      else if (eos_wr) hold <= HOLD_W'(HOLDOFF_CYC - 3);
      else if (hold != '0) hold <= hold - 1'b1;
   end
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("APB access without ready");
   unmapped_err_a: assert property (psel && penable && paddr > OFS_STAT |-> pslverr)
      else $error("unmapped access without error");
   reset_quiet_a: assert property (disable iff (1'b0) !rst_n |=> transfer_ack_n && periph_ack_n && !periph_busy)
      else $error("handshake outputs active after reset");
   ack_early_a: assert property ($fell(transfer_ack_n) && host_in.dma_acknowledge_n |->
      $past(host_in.data_strobe_n, 3) == 1'b0) else $error("acknowledge before third cycle");
   holdoff_gap_a: assert property ($fell(transfer_ack_n) |-> hold == '0)
      else $error("acknowledge inside hold-off");
   data_release_a: assert property ($rose(transfer_ack_n) |-> ##2 !host_data_oe)
      else $error("data bus still driven after release");
   ack_pullup_a: assert property ($rose(transfer_ack_n) |-> transfer_ack_oe ##2 !transfer_ack_oe)
      else $error("acknowledge pull-up phase wrong");
   busy_wraps_a: assert property (!periph_ack_n |-> periph_busy)
      else $error("acknowledge outside busy");
   ack_width_a: assert property ($rose(periph_ack_n) |-> ack_len >= ACK_BASE_CYC)
      else $error("link acknowledge too short");
endmodule
bind ppc_port ppc_port_assertions i_ppc_port_assertions (.*);

// File: dv/ppc_host_model.sv
// Host processor bus with DMA controller, facing the host pins of ppc_port.
// Assumes one caller at a time; pins move only by NBA after a rising edge.
`timescale 1ns/1ps
module ppc_host_model
   import ppc_pkg::*;
(
   // Clock
   input  wire logic              sys_clk,
   // Device answers
   input  wire logic              transfer_ack_n,
   input  wire logic              dma_request_n,
   input  wire logic [BYTE_W-1:0] host_data_out,
   // Driven pins
   output ppc_host_in_t           host_in
);
   initial host_in = HOST_IN_IDLE;
   // Host read; waits for acknowledge, so an access started inside a hold-off only takes longer
   task automatic host_read(output logic [BYTE_W-1:0] d, output int lat);
      int n;
      lat = 0;
      @(posedge sys_clk);
      host_in.cs_n <= 1'b0;
      host_in.data_strobe_n <= 1'b0;
      host_in.data <= ~host_in.data; // Not driven by host: keep it moving
      do begin @(posedge sys_clk); lat++; end while (transfer_ack_n !== 1'b0 && lat < 100);
      d = host_data_out;
      host_in.cs_n <= 1'b1;
      host_in.data_strobe_n <= 1'b1;
      n = 0;
      while (transfer_ack_n !== 1'b1 && n < 100) begin @(posedge sys_clk); n++; end
   endtask
   // DMA burst: acknowledge held low until the device stops requesting
   task automatic dma_drain(output int n);
      n = 0;
      @(posedge sys_clk);
      host_in.dma_acknowledge_n <= 1'b0;
      do begin @(posedge sys_clk); n++; end while (dma_request_n !== 1'b1 && n < 100);
      host_in.dma_acknowledge_n <= 1'b1;
   endtask
endmodule

// File: dv/ppc_port_tb.sv
// Self-checking bench for ppc_port: APB registers, host reads, link and DMA.
// Assumes the host model and bound checker; the bench plays the 1284 host.
`timescale 1ns/1ps
module ppc_port_tb;
   import ppc_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic transfer_ack_n, dma_request_n, periph_ack_n, periph_busy;
   logic [BYTE_W-1:0] host_data_out, periph_data;
   ppc_host_in_t host_in;
   ppc_link_in_t link_in;
   int errors, total_checks, cycles;
   // Design, ce held high
   ppc_port i_ppc_port (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .host_in(host_in), .host_data_out(host_data_out),
      .host_data_oe(), .transfer_ack_n(transfer_ack_n), .transfer_ack_oe(),
      .chain_grant_out_n(), .dma_request_n(dma_request_n), .link_in(link_in), .periph_data(periph_data),
      .periph_data_oe(), .periph_ack_n(periph_ack_n), .periph_busy(periph_busy),
      .dir_change_flag());
   ppc_host_model i_ppc_host_model (.sys_clk(sys_clk), .transfer_ack_n(transfer_ack_n),
      .dma_request_n(dma_request_n), .host_data_out(host_data_out), .host_in(host_in));
   always #10 sys_clk = ~sys_clk;
   // Hang guard, well above the longest expected run
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end
   task automatic close_out();
      if (errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] r, output logic e);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, v, r, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, r, e);
   endtask
   // One byte from the 1284 host; w returns the acknowledge low time
   task automatic link_send(input logic [7:0] b, output int w);
      int n;
      n = 0;
      while (periph_busy !== 1'b0 && n < 4000) begin @(posedge sys_clk); n++; end
      @(posedge sys_clk);
      link_in.data <= b;
      link_in.strobe_n <= 1'b0;
      repeat (3) @(posedge sys_clk);
      link_in.strobe_n <= 1'b1;
      w = 0;
      while (periph_ack_n !== 1'b0 && n < 4200) begin @(posedge sys_clk); n++; end
      while (periph_ack_n === 1'b0 && w < 4000) begin @(posedge sys_clk); w++; end
      link_in.data <= ~b;
   endtask
   // Main sequence
   initial begin
      logic [31:0] d;
      logic e;
      logic [7:0] hb;
      int w, lat;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      link_in = LINK_IN_IDLE;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(OFS_PULSE, d); check("pulse reset", d, {24'h0, PULSE_RESET});
      rd(OFS_QTY, d); check("qty reset", d, 32'h0);
      apb(1'b0, 8'h20, 32'h0, d, e); check("unmapped", {31'h0, e}, 32'h1);
      link_send(8'hA5, w); check("ack width", w, ACK_BASE_CYC);
      wr(OFS_PULSE, 32'h2);
      link_send(8'h5A, w); check("ack long", w, ACK_BASE_CYC + 2 * ACK_STEP_CYC);
      rd(OFS_QTY, d); check("qty two", d, 32'h2);
      i_ppc_host_model.host_read(hb, lat);
      check("host byte", {24'h0, hb}, 32'hA5);
      check("ack prompt", lat, 32'h6);
      wr(OFS_EOS, 32'h0);
      i_ppc_host_model.host_read(hb, lat);
      check("held byte", {24'h0, hb}, 32'h5A);
      check("hold-off", {31'h0, lat >= HOLDOFF_CYC}, 32'h1);
      link_send(8'hC3, w);
      link_send(8'hC3, w);
      rd(OFS_RLE, d); check("rle count", d, 32'h1);
      wr(OFS_PAC, 32'h1);
      link_in.dir_reverse <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check("reverse byte", {24'h0, periph_data}, 32'hC3);
      link_in.dir_reverse <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(OFS_STAT, d); check("dir change", {31'h0, d[STAT_DIRCH]}, 32'h1);
      wr(OFS_PAC, 32'h4);
      rd(OFS_PAC, d); check("pac forward", d, 32'h0);
      rd(OFS_QTY, d); check("qty flushed", d, 32'h0);
      rd(OFS_RLE, d); check("rle flushed", d, 32'h0);
      wr(OFS_STAT, 32'h1);
      rd(OFS_STAT, d); check("dir cleared", {31'h0, d[STAT_DIRCH]}, 32'h0);
      link_send(8'h11, w);
      link_send(8'h22, w);
      i_ppc_host_model.dma_drain(lat);
      check("dma time", {31'h0, lat <= 12}, 32'h1);
      rd(OFS_QTY, d); check("qty dma", d, 32'h0);
      // Async mode: one transfer per acknowledge, so one byte stays queued
      wr(OFS_PAC, 32'h2);
      link_send(8'h33, w);
      link_send(8'h44, w);
      i_ppc_host_model.dma_drain(lat);
      rd(OFS_QTY, d); check("qty async", d, 32'h1);
      close_out();
   end
endmodule
